//--- hdl/rim_mapper.v
// remote input/output signal mapper with apb configuration
//
// The register offsets and the APB slave port are this design's own decisions.
`include "rim_regs.vh"

// Functional notes
// - each remote input bit drives the function its map field selects; none means no effect
// - input map fields reset to the default function assignment per bit
// - run levels give continuous run; dropping to 0 gives a decelerating stop
// - homing, launch, sequence, inch inputs start their operation on a 0-to-1 transition
// - each direct select starts direct positioning with its own configured data number
// - six data-number inputs form a binary data number 0 to 63
// - brake release input de-energizes windings and releases brake while 1
// - excitation enable energizes the motor while 1, de-energizes while 0
// - stop input at 1 stops motor operation
// - fault clear and abs position fault clear act on a 1-to-0 transition
// - position load presets the command position on a 0-to-1 transition
// - a function mapped to several bits is active when any of them is
// - unmapped excitation enable or panel unlock is treated as constantly 1
// - when mapped on both direct and remote inputs, both must be 1
// - panel unlock lifts tool limitation while 1; general flags stored and reported
// - each remote output bit shows the source its map field selects
// - echo outputs mirror the current state of their matching input
// - fault flag follows alarm presence, caution flag follows warning presence
// - ready, running, positioning done and at-origin flags follow driver state
// - torque flag and three zone flags follow driver state
// - rotation tick pulses once per 7.2 degrees of shaft rotation
// - internal processing flag and mains-on flag follow driver state
module rim_mapper #(
  parameter TICK_STEPS = `RIM_TICK_STEPS
) (
  input  wire        clk_i,
  input  wire        srst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // remote words from/to the network converter
  input  wire [15:0] remote_input_bit_i,
  output reg  [15:0] remote_output_bit_o,
  // direct i/o pins
  input  wire        direct_exc_enable_i,
  input  wire        direct_exc_mapped_i,
  input  wire        direct_panel_unlock_i,
  input  wire        direct_unlock_mapped_i,
  input  wire        limit_pos_sensor_i,
  input  wire        limit_neg_sensor_i,
  input  wire        origin_sensor_i,
  input  wire        slot_sensor_i,
  // driver state
  input  wire        alarm_present_i,
  input  wire        warning_present_i,
  input  wire        driver_ready_i,
  input  wire        motor_moving_i,
  input  wire        position_done_i,
  input  wire        at_home_i,
  input  wire        torque_outside_i,
  input  wire [2:0]  zone_inside_i,
  input  wire        internal_busy_i,
  input  wire        mains_present_i,
  input  wire        motor_step_i,
  // commands to the driver
  output reg         run_positive_o,
  output reg         run_negative_o,
  output reg         homing_start_o,
  output reg         launch_start_o,
  output reg         sequence_start_o,
  output reg         inch_positive_start_o,
  output reg         inch_negative_start_o,
  output reg         direct_start_o,
  output reg  [5:0]  direct_data_number_o,
  output reg  [5:0]  data_number_o,
  output reg         brake_release_o,
  output reg         energize_o,
  output reg         stop_o,
  output reg         fault_clear_o,
  output reg         abs_pos_fault_clear_o,
  output reg         position_load_o,
  output reg         panel_unlock_o,
  output reg  [15:0] general_flag_n_o
);

  // ---------------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------------
  reg  [7:0]  in_map  [0:15];
  reg  [7:0]  out_map [0:15];
  reg  [7:0]  dsel_map [0:5];
  reg  [31:0] rdata;
  reg         rerr;
  reg  [15:0] in_q;
  // all reset words in one vector so each field is a plain part-select
  wire [319:0] map_rst = {`RIM_DSEL1_RST, `RIM_DSEL0_RST, `RIM_OUTMAP3_RST, `RIM_OUTMAP2_RST, `RIM_OUTMAP1_RST,
                          `RIM_OUTMAP0_RST, `RIM_INMAP3_RST, `RIM_INMAP2_RST, `RIM_INMAP1_RST, `RIM_INMAP0_RST};
  wire        wr_en = psel_i & penable_i & pwrite_i;
  integer     k;

  // zero wait states: every access finishes in its first access cycle
  assign pready_o  = 1'b1;
  assign prdata_o  = (psel_i & penable_i & ~pwrite_i) ? rdata : 32'h0000_0000;
  assign pslverr_o = psel_i & penable_i & rerr;

  // map writes; only whole words, apb3 has no byte strobes
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        in_map[k]       <= map_rst[8 * k +: 8];
        in_map[k + 4]   <= map_rst[32 + 8 * k +: 8];
        in_map[k + 8]   <= map_rst[64 + 8 * k +: 8];
        in_map[k + 12]  <= map_rst[96 + 8 * k +: 8];
        out_map[k]      <= map_rst[128 + 8 * k +: 8];
        out_map[k + 4]  <= map_rst[160 + 8 * k +: 8];
        out_map[k + 8]  <= map_rst[192 + 8 * k +: 8];
        out_map[k + 12] <= map_rst[224 + 8 * k +: 8];
        dsel_map[k]     <= map_rst[256 + 8 * k +: 8];
      end
      dsel_map[4] <= map_rst[295:288];
      dsel_map[5] <= map_rst[303:296];
    end
    else if (wr_en)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        case (paddr_i)
          `RIM_INMAP0_OFS:  in_map[k]       <= pwdata_i[8 * k +: 8];
          `RIM_INMAP1_OFS:  in_map[k + 4]   <= pwdata_i[8 * k +: 8];
          `RIM_INMAP2_OFS:  in_map[k + 8]   <= pwdata_i[8 * k +: 8];
          `RIM_INMAP3_OFS:  in_map[k + 12]  <= pwdata_i[8 * k +: 8];
          `RIM_OUTMAP0_OFS: out_map[k]      <= pwdata_i[8 * k +: 8];
          `RIM_OUTMAP1_OFS: out_map[k + 4]  <= pwdata_i[8 * k +: 8];
          `RIM_OUTMAP2_OFS: out_map[k + 8]  <= pwdata_i[8 * k +: 8];
          `RIM_OUTMAP3_OFS: out_map[k + 12] <= pwdata_i[8 * k +: 8];
          `RIM_DSEL0_OFS:   dsel_map[k]     <= pwdata_i[8 * k +: 8];
          `RIM_DSEL1_OFS:
          begin
            if (k < 2)
              dsel_map[k + 4] <= pwdata_i[8 * k +: 8];
          end
          default: ;
        endcase
      end
    end
  end

  // read mux; unmapped offsets answer zero with pslverr
  always @*
  begin
    rdata = 32'h0000_0000;
    rerr  = 1'b0;
    case (paddr_i)
      `RIM_INMAP0_OFS:  rdata = {in_map[3], in_map[2], in_map[1], in_map[0]};
      `RIM_INMAP1_OFS:  rdata = {in_map[7], in_map[6], in_map[5], in_map[4]};
      `RIM_INMAP2_OFS:  rdata = {in_map[11], in_map[10], in_map[9], in_map[8]};
      `RIM_INMAP3_OFS:  rdata = {in_map[15], in_map[14], in_map[13], in_map[12]};
      `RIM_OUTMAP0_OFS: rdata = {out_map[3], out_map[2], out_map[1], out_map[0]};
      `RIM_OUTMAP1_OFS: rdata = {out_map[7], out_map[6], out_map[5], out_map[4]};
      `RIM_OUTMAP2_OFS: rdata = {out_map[11], out_map[10], out_map[9], out_map[8]};
      `RIM_OUTMAP3_OFS: rdata = {out_map[15], out_map[14], out_map[13], out_map[12]};
      `RIM_DSEL0_OFS:   rdata = {dsel_map[3], dsel_map[2], dsel_map[1], dsel_map[0]};
      `RIM_DSEL1_OFS:   rdata = {16'h0000, dsel_map[5], dsel_map[4]};
      `RIM_IOSTAT_OFS:  rdata = {remote_output_bit_o, in_q};
      `RIM_CMDSTAT_OFS: rdata = {16'h0000, general_flag_n_o};
      default:          rerr  = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------
  // input sampling and pin synchronisers
  // ---------------------------------------------------------------------
  reg [7:0]  pin_meta;
  reg [7:0]  pin_sync;

  // converter logic shares the clock, so one register is enough for it
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      in_q     <= 16'h0000;
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      in_q     <= remote_input_bit_i;
      pin_meta <= {direct_exc_enable_i, direct_exc_mapped_i, direct_panel_unlock_i, direct_unlock_mapped_i,
                   limit_pos_sensor_i, limit_neg_sensor_i, origin_sensor_i, slot_sensor_i};
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------------
  reg  [63:0] func_now;
  reg  [63:0] func_mapped;
  reg  [63:0] func_prev;
  reg  [5:0]  fidx;
  integer     i;

  // duplicates simply or together; code zero is dropped below
  always @*
  begin
    func_now    = 64'h0000_0000_0000_0000;
    func_mapped = 64'h0000_0000_0000_0000;
    fidx        = 6'h00;
    for (i = 0; i < 16; i = i + 1)
    begin
      fidx = in_map[i][5:0];
      func_mapped[fidx] = 1'b1;
      if (in_q[i])
        func_now[fidx] = 1'b1;
    end
    func_now[`RIM_F_NONE] = 1'b0;
  end

  // previous sample for edge detection
  always @(posedge clk_i)
  begin
    if (srst_i)
      func_prev <= 64'h0000_0000_0000_0000;
    else
      func_prev <= func_now;
  end

  wire [63:0] rise = func_now & ~func_prev;
  wire [63:0] fall = ~func_now & func_prev;

  // unmapped means 1, and a mapped direct pin must agree as well
  wire exc_eff = (func_mapped[`RIM_F_EXC] ? func_now[`RIM_F_EXC] : 1'b1)
               & (pin_sync[6] ? pin_sync[7] : 1'b1);
  wire unlock_eff = (func_mapped[`RIM_F_UNLOCK] ? func_now[`RIM_F_UNLOCK] : 1'b1)
                  & (pin_sync[4] ? pin_sync[5] : 1'b1);

  // lowest-numbered direct select wins if two rise together
  reg [5:0] dsel_num;
  reg       dsel_go;
  integer   j;
  always @*
  begin
    dsel_num = 6'h00;
    dsel_go  = 1'b0;
    for (j = 5; j >= 0; j = j - 1)
    begin
      if (rise[`RIM_F_DSEL0 + j])
      begin
        dsel_go  = 1'b1;
        dsel_num = dsel_map[j][5:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // driver commands
  // ---------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      run_positive_o        <= 1'b0;
      run_negative_o        <= 1'b0;
      homing_start_o        <= 1'b0;
      launch_start_o        <= 1'b0;
      sequence_start_o      <= 1'b0;
      inch_positive_start_o <= 1'b0;
      inch_negative_start_o <= 1'b0;
      direct_start_o        <= 1'b0;
      direct_data_number_o  <= 6'h00;
      data_number_o         <= 6'h00;
      brake_release_o       <= 1'b0;
      energize_o            <= 1'b0;
      stop_o                <= 1'b0;
      fault_clear_o         <= 1'b0;
      abs_pos_fault_clear_o <= 1'b0;
      position_load_o       <= 1'b0;
      panel_unlock_o        <= 1'b0;
      general_flag_n_o      <= 16'h0000;
    end
    else
    begin
      run_positive_o        <= func_now[`RIM_F_RUNP];
      run_negative_o        <= func_now[`RIM_F_RUNN];
      // starts are pulses so a held level launches only once
      homing_start_o        <= rise[`RIM_F_HOME];
      launch_start_o        <= rise[`RIM_F_LAUNCH];
      sequence_start_o      <= rise[`RIM_F_SEQ];
      inch_positive_start_o <= rise[`RIM_F_INCHP];
      inch_negative_start_o <= rise[`RIM_F_INCHN];
      direct_start_o        <= dsel_go;
      if (dsel_go)
        direct_data_number_o <= dsel_num;
      data_number_o         <= func_now[`RIM_F_DNUM0 +: 6];
      brake_release_o       <= func_now[`RIM_F_FREE];
      energize_o            <= exc_eff & ~func_now[`RIM_F_FREE];
      stop_o                <= func_now[`RIM_F_STOP];
      fault_clear_o         <= fall[`RIM_F_FCLR];
      abs_pos_fault_clear_o <= fall[`RIM_F_ACLR];
      position_load_o       <= rise[`RIM_F_PLOAD];
      panel_unlock_o        <= unlock_eff;
      general_flag_n_o      <= func_now[`RIM_F_GFLAG0 +: 16];
    end
  end

  // ---------------------------------------------------------------------
  // rotation tick
  // ---------------------------------------------------------------------
  reg [15:0] step_cnt;
  reg        tick;

  // step count per tick is set by the motor resolution, hence a parameter
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      step_cnt <= 16'h0000;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (motor_step_i)
      begin
        if (step_cnt >= TICK_STEPS[15:0] - 16'h0001)
        begin
          step_cnt <= 16'h0000;
          tick     <= 1'b1;
        end
        else
          step_cnt <= step_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // remote output word
  // ---------------------------------------------------------------------
  reg [127:0] src;
  reg [15:0]  next_out;
  integer     m;

  always @*
  begin
    src = 128'h0;
    src[63:0] = func_now;
    src[`RIM_F_EXC]     = exc_eff;
    src[`RIM_F_UNLOCK]  = unlock_eff;
    src[`RIM_S_LIMP]    = pin_sync[3];
    src[`RIM_S_LIMN]    = pin_sync[2];
    src[`RIM_S_ORIGIN]  = pin_sync[1];
    src[`RIM_S_SLOT]    = pin_sync[0];
    src[`RIM_S_FAULT]   = alarm_present_i;
    src[`RIM_S_CAUTION] = warning_present_i;
    src[`RIM_S_READY]   = driver_ready_i;
    src[`RIM_S_RUNNING] = motor_moving_i;
    src[`RIM_S_DONE]    = position_done_i;
    src[`RIM_S_ATORG]   = at_home_i;
    src[`RIM_S_TORQUE]  = torque_outside_i;
    src[`RIM_S_TICK]    = tick;
    src[`RIM_S_ZONE1 +: 3] = zone_inside_i;
    src[`RIM_S_BUSY]    = internal_busy_i;
    src[`RIM_S_MAINS]   = mains_present_i;
    next_out = 16'h0000;
    for (m = 0; m < 16; m = m + 1)
      next_out[m] = src[out_map[m][6:0]];
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
      remote_output_bit_o <= 16'h0000;
    else
      remote_output_bit_o <= next_out;
  end

endmodule // rim_mapper

//--- hdl/rim_regs.vh
// register offsets, field layout and reset values of the remote i/o signal mapper
`ifndef RIM_REGS_VH
`define RIM_REGS_VH
// apb byte offsets, each register one aligned 32-bit word
`define RIM_INMAP0_OFS   12'h000
`define RIM_INMAP1_OFS   12'h004
`define RIM_INMAP2_OFS   12'h008
`define RIM_INMAP3_OFS   12'h00C
`define RIM_OUTMAP0_OFS  12'h010
`define RIM_OUTMAP1_OFS  12'h014
`define RIM_OUTMAP2_OFS  12'h018
`define RIM_OUTMAP3_OFS  12'h01C
`define RIM_DSEL0_OFS    12'h020
`define RIM_DSEL1_OFS    12'h024
`define RIM_IOSTAT_OFS   12'h028
`define RIM_CMDSTAT_OFS  12'h02C
// four 8-bit map fields per word (two in DSEL1), field k at bits 8k+7:8k
`define RIM_FIELD_W      8
// input function codes
`define RIM_F_NONE       6'h00
`define RIM_F_RUNP       6'h01
`define RIM_F_RUNN       6'h02
`define RIM_F_HOME       6'h03
`define RIM_F_LAUNCH     6'h04
`define RIM_F_SEQ        6'h05
`define RIM_F_INCHP      6'h06
`define RIM_F_INCHN      6'h07
`define RIM_F_DSEL0      6'h08
`define RIM_F_FREE       6'h0E
`define RIM_F_EXC        6'h0F
`define RIM_F_STOP       6'h10
`define RIM_F_FCLR       6'h11
`define RIM_F_PLOAD      6'h12
`define RIM_F_ACLR       6'h13
`define RIM_F_UNLOCK     6'h14
`define RIM_F_DNUM0      6'h15
`define RIM_F_GFLAG0     6'h20
// output source codes; 1..47 echo the input function of the same code
`define RIM_S_LIMP       7'h30
`define RIM_S_LIMN       7'h31
`define RIM_S_ORIGIN     7'h32
`define RIM_S_SLOT       7'h33
`define RIM_S_FAULT      7'h34
`define RIM_S_CAUTION    7'h35
`define RIM_S_READY      7'h36
`define RIM_S_RUNNING    7'h37
`define RIM_S_DONE       7'h38
`define RIM_S_ATORG      7'h39
`define RIM_S_TORQUE     7'h3A
`define RIM_S_TICK       7'h3B
`define RIM_S_ZONE1      7'h3C
`define RIM_S_BUSY       7'h3F
`define RIM_S_MAINS      7'h40
// reset values of the map registers
`define RIM_INMAP0_RST   32'h0417_1615
`define RIM_INMAP1_RST   32'h000E_1003
`define RIM_INMAP2_RST   32'h050A_0908
`define RIM_INMAP3_RST   32'h0201_0706
`define RIM_OUTMAP0_RST  32'h0417_1615
`define RIM_OUTMAP1_RST  32'h3435_3639
`define RIM_OUTMAP2_RST  32'h3E3D_3C3F
`define RIM_OUTMAP3_RST  32'h3A38_373B
`define RIM_DSEL0_RST    32'h0302_0100
`define RIM_DSEL1_RST    32'h0000_0504
// motor steps counted per 7.2 degree tick
`define RIM_TICK_STEPS   16'h000A
`endif

//--- tb/rim_mapper_chk.sv
// port-level assertions for the remote i/o signal mapper
module rim_mapper_chk #(
  parameter TICK_STEPS = 10
) (
  input wire        clk_i,
  input wire        srst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [15:0] remote_input_bit_i,
  input wire [15:0] remote_output_bit_o,
  input wire        alarm_present_i,
  input wire        torque_outside_i,
  input wire        run_positive_o,
  input wire        homing_start_o,
  input wire        fault_clear_o,
  input wire        brake_release_o,
  input wire        energize_o,
  input wire [5:0]  data_number_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // ----------------
  // apb slave
  // ----------------
  // zero-wait slave: a master must never stall on it
  apb_ready_a: assert property (pready_o)
    else $error("pready low");
  idle_bus_a: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0000_0000 && !pslverr_o)
    else $error("bus output outside access");
  // ----------------
  // commands, two register stages behind the remote word
  // ----------------
  run_level_a: assert property (!$past(srst_i) && !$past(srst_i, 2) && $past(remote_input_bit_i[14], 2)
    |-> run_positive_o) else $error("run level missing");
  data_num_a: assert property (!$past(srst_i) && !$past(srst_i, 2)
    |-> data_number_o == {3'b000, $past(remote_input_bit_i[2:0], 2)}) else $error("data number wrong");
  home_rise_a: assert property (!$past(srst_i) && !$past(srst_i, 2) && $past(remote_input_bit_i[4], 2)
    && !$past(remote_input_bit_i[4], 3) |-> homing_start_o) else $error("homing start missing");
  home_once_a: assert property (homing_start_o |=> !homing_start_o)
    else $error("homing start too long");
  clear_once_a: assert property (fault_clear_o |=> !fault_clear_o)
    else $error("fault clear too long");
  brake_free_a: assert property (brake_release_o |-> !energize_o)
    else $error("energized during brake release");
  // ----------------
  // status word, one edge behind driver state
  // ----------------
  fault_out_a: assert property (!$past(srst_i) |-> remote_output_bit_o[7] == $past(alarm_present_i))
    else $error("fault flag wrong");
  torque_out_a: assert property (!$past(srst_i) |-> remote_output_bit_o[15] == $past(torque_outside_i))
    else $error("torque flag wrong");
  run_c: cover property (run_positive_o);
  home_c: cover property (homing_start_o);
  clear_c: cover property (fault_clear_o);
endmodule // rim_mapper_chk

bind rim_mapper rim_mapper_chk #(.TICK_STEPS(TICK_STEPS)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .remote_input_bit_i(remote_input_bit_i),
  .remote_output_bit_o(remote_output_bit_o), .alarm_present_i(alarm_present_i),
  .torque_outside_i(torque_outside_i), .run_positive_o(run_positive_o), .homing_start_o(homing_start_o),
  .fault_clear_o(fault_clear_o), .brake_release_o(brake_release_o), .energize_o(energize_o),
  .data_number_o(data_number_o)
);

//--- tb/rim_net_ctrl.sv
// network converter model that hands the remote word to the driver
module rim_net_ctrl (
  input  wire         clk_i,
  input  wire  [15:0] status_i,
  output logic [15:0] cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle word selects nothing
  initial cmd_o = 16'h0000;
  // low byte is bits 0-7, high byte bits 8-15; changes only after an edge
  task automatic send(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk_i);
    cmd_o <= {hi, lo};
  endtask
endmodule // rim_net_ctrl

//--- tb/test_remote_io_signal_mapper.sv
// self-checking bench for the remote i/o signal mapper
`include "rim_regs.vh"
module test_remote_io_signal_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 2;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [7:0]  pin = 8'h00;
  logic [11:0] st = 12'h000;
  logic        step = 1'b0;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire  [15:0] rin;
  wire  [15:0] rout;
  wire  [5:0]  lev;
  wire  [8:0]  pul;
  wire  [5:0]  ddn;
  wire  [5:0]  dn;
  wire  [15:0] gf;
  int          num_errors = 0;
  int          tests_run = 0;
  int          n;
  logic [31:0] q;
  logic        e;
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  rim_net_ctrl u_net (.clk_i(clk_i), .status_i(rout), .cmd_o(rin));
  rim_mapper #(.TICK_STEPS(TICK)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .remote_input_bit_i(rin), .remote_output_bit_o(rout), .direct_exc_enable_i(pin[0]),
    .direct_exc_mapped_i(pin[1]), .direct_panel_unlock_i(pin[2]), .direct_unlock_mapped_i(pin[3]),
    .limit_pos_sensor_i(pin[4]), .limit_neg_sensor_i(pin[5]), .origin_sensor_i(pin[6]), .slot_sensor_i(pin[7]),
    .alarm_present_i(st[11]), .warning_present_i(st[10]), .driver_ready_i(st[9]), .motor_moving_i(st[8]),
    .position_done_i(st[7]), .at_home_i(st[6]), .torque_outside_i(st[5]), .zone_inside_i(st[4:2]),
    .internal_busy_i(st[1]), .mains_present_i(st[0]), .motor_step_i(step),
    .run_positive_o(lev[0]), .run_negative_o(lev[1]), .homing_start_o(pul[1]), .launch_start_o(pul[0]),
    .sequence_start_o(pul[2]), .inch_positive_start_o(pul[3]), .inch_negative_start_o(pul[4]),
    .direct_start_o(pul[5]), .direct_data_number_o(ddn), .data_number_o(dn), .brake_release_o(lev[2]),
    .energize_o(lev[3]), .stop_o(lev[4]), .fault_clear_o(pul[6]), .abs_pos_fault_clear_o(pul[7]),
    .position_load_o(pul[8]), .panel_unlock_o(lev[5]), .general_flag_n_o(gf)
  );
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; no wait count assumed, the watchdog cuts a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic send(input logic [15:0] v);
    u_net.send(v[7:0], v[15:8]);
  endtask
  // sample just after the edge so register updates have landed
  task automatic w(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic cnt(input int i);
    n = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      #1;
      if (pul[i] === 1'b1) n++;
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    logic [31:0] tab [10];
    tab = '{`RIM_INMAP0_RST, `RIM_INMAP1_RST, `RIM_INMAP2_RST, `RIM_INMAP3_RST, `RIM_OUTMAP0_RST,
            `RIM_OUTMAP1_RST, `RIM_OUTMAP2_RST, `RIM_OUTMAP3_RST, `RIM_DSEL0_RST, `RIM_DSEL1_RST};
    for (int k = 0; k < 10; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0000_0000);
      chk(q, tab[k]);
    end
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  task automatic t_run();
    send(16'h4000);
    w(3);
    chk(lev[1:0], 2'b01);
    send(16'h8000);
    w(3);
    chk(lev[1:0], 2'b10);
    send(16'h0080);
    w(3);
    chk(lev, 6'h28);
    apb(1'b1, `RIM_INMAP1_OFS, 32'h010E_1003);
    send(16'h0080);
    w(3);
    chk(lev[0], 1'b1);
  endtask
  task automatic t_starts();
    int bt [5];
    bt = '{3, 4, 11, 12, 13};
    for (int k = 0; k < 5; k++)
    begin
      send(16'h0001 << bt[k]);
      cnt(k);
      chk(n, 1);
      send(16'h0000);
      cnt(k);
      chk(n, 0);
    end
  endtask
  task automatic t_direct();
    apb(1'b1, `RIM_DSEL0_OFS, 32'h0302_2A00);
    send(16'h0200);
    cnt(5);
    chk(n, 1);
    chk(ddn, 6'h2A);
    send(16'h0005);
    w(3);
    chk(dn, 6'h05);
    chk(rout[2:0], 3'h5);
    apb(1'b0, `RIM_IOSTAT_OFS, 32'h0000_0000);
    chk(q, 32'h0005_0005);
  endtask
  task automatic t_stop();
    send(16'h0060);
    w(3);
    chk(lev[4], 1'b1);
    chk(lev[3:2], 2'b01);
  endtask
  // excitation and flags both share remote bit 7
  task automatic t_exc();
    apb(1'b1, `RIM_INMAP1_OFS, 32'h0F0E_1003);
    pin <= 8'h0F;
    send(16'h0080);
    w(6);
    chk(lev[3], 1'b1);
    @(posedge clk_i);
    pin <= 8'h0E;
    w(6);
    chk(lev[3], 1'b0);
    @(posedge clk_i);
    pin <= 8'h0F;
    send(16'h0000);
    w(6);
    chk(lev[3], 1'b0);
    apb(1'b1, `RIM_INMAP1_OFS, 32'h230E_1003);
    send(16'h0080);
    w(3);
    chk(gf, 16'h0008);
    apb(1'b0, `RIM_CMDSTAT_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0008);
  endtask
  task automatic t_edges();
    apb(1'b1, `RIM_INMAP2_OFS, 32'h1213_1108);
    for (int k = 0; k < 3; k++)
    begin
      send(16'h0200 << k);
      cnt(6 + k);
      chk(n, k == 2);
      send(16'h0000);
      cnt(6 + k);
      chk(n, k != 2);
    end
  endtask
  task automatic t_status();
    logic [11:0] p;
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 12'h5A5 : 12'hA5A;
      @(posedge clk_i);
      st <= p;
      w(3);
      chk(rout[15:4], {p[5], p[7], p[8], 1'b0, p[4:2], p[1], p[11], p[10], p[9], p[6]});
    end
    apb(1'b1, `RIM_OUTMAP0_OFS, 32'h0400_3040);
    pin <= 8'h1F;
    send(16'h0004);
    w(6);
    chk(rout[2:0], {1'b0, 1'b1, p[0]});
  endtask
  task automatic t_tick();
    n = 0;
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clk_i);
      step <= (k < 8) && !k[0];
      #1;
      if (rout[12] === 1'b1) n++;
    end
    chk(n, 4 / TICK);
  endtask
  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_run();
    t_starts();
    t_direct();
    t_stop();
    t_exc();
    t_edges();
    t_status();
    t_tick();
    close_out();
  end
endmodule // test_remote_io_signal_mapper
